//--- design/rsm_pkg.sv
// shared constants, types and register map of the reclose settings memory
package rsm_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CT = 8'h04;
    localparam logic [7:0] A_SEQ = 8'h08;
    localparam logic [7:0] A_STN = 8'h0C;
    localparam logic [7:0] A_LOGIN = 8'h10;
    localparam logic [7:0] A_CALSEL = 8'h14;
    localparam logic [7:0] A_CALDAT = 8'h18;
    localparam logic [7:0] A_STAT = 8'h1C;
    localparam int CTRL_RPM = 0;
    localparam int CTRL_REN = 1;
    localparam int CTRL_ORS = 2;
    localparam int CTRL_DMD = 8;
    localparam int CTRL_BAUD = 12;
    localparam int CT_GND = 16;
    localparam int SEQ_NPER = 8;
    localparam int SEQ_HOLD = 16;
    localparam int CAL_IDX = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [9:0] CT_RST = 10'h001;
    localparam logic [9:0] CT_MAX = 10'h3E8;
    localparam logic [7:0] DLY_RST = 8'h0F;
    localparam logic [7:0] HOLD_RST = 8'h0A;
    localparam logic [7:0] HOLD_MAX = 8'h9F;
    localparam logic [13:0] STN_MAX = 14'h270F;
    localparam logic [6:0] CAL_MAX = 7'h63;
    localparam logic [6:0] CAL_UNITY = 7'h32;
    localparam int CAL_CNT = 12;
    localparam int CAL_BASE = 950;
    localparam int CAL_DIV = 1000;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_S;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RESET = 3'b001,
        ST_CYCLE = 3'b010,
        ST_HOLD = 3'b011,
        ST_LOCKOUT = 3'b100,
        ST_DOWN = 3'b101
    } rsm_state_t;
    typedef struct packed {
        logic [1:0] gain;
        logic [3:0][15:0] amps;
    } rsm_meas_t;
    typedef struct packed {
        logic [13:0] baud_rate;
        logic [5:0] demand_minutes;
    } rsm_comm_t;
endpackage : rsm_pkg

//--- design/rsm_calmem.sv
// calibration code store with registered read ports
`timescale 1ns/1ps
module rsm_calmem
    import rsm_pkg::*;
#(
    parameter int DEPTH = 12,
    parameter int NRD = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [6:0] wdata,
    input wire logic [NRD-1:0][3:0] raddr,
    output logic [NRD-1:0][6:0] rdata
);
    logic [DEPTH-1:0][6:0] mem_r;
    initial begin
        if (DEPTH > 16 || NRD < 1) $error("rsm_calmem: unsupported size");
    end
    // unprogrammed codes start at unity so an empty store does not skew currents
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_r <= {DEPTH{CAL_UNITY}};
        end else if (we && 32'(waddr) < DEPTH) begin
            mem_r[waddr] <= wdata;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata <= '0;
        end else begin
            for (int i = 0; i < NRD; i++) begin
                rdata[i] <= (32'(raddr[i]) < DEPTH) ? mem_r[raddr[i]] : 7'h00;
            end
        end
    end
endmodule : rsm_calmem

//--- design/rsm_scale.sv
// one channel: secondary current to corrected primary current
`timescale 1ns/1ps
module rsm_scale
    import rsm_pkg::*;
#(
    parameter int IW = 16,
    parameter int OW = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [IW-1:0] amps,
    input wire logic [9:0] ratio,
    input wire logic [6:0] code,
    output logic [OW-1:0] primary
);
    logic [IW+23:0] prod;
    logic [IW+23:0] quot;
    initial begin
        if (IW < 1 || OW < IW + 11) $error("rsm_scale: output too narrow");
    end
    assign prod = (IW+24)'(amps) * (IW+24)'(ratio) * (IW+24)'(CAL_BASE + 32'(code));
    assign quot = prod / (IW+24)'(CAL_DIV);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            primary <= '0;
        end else begin
            primary <= OW'(quot);
        end
    end
endmodule : rsm_scale

//--- design/rsm_top.sv
// reclose settings decoder, power-loss memory and ahb-lite register slave
`timescale 1ns/1ps
module rsm_top
    import rsm_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic power_ok,
    input wire logic breaker_closed,
    input wire logic trip,
    input wire rsm_meas_t meas,
    output logic [3:0][31:0] amps_primary,
    output rsm_comm_t comm,
    output logic login_ok,
    output logic reclose_out,
    output logic spare_output,
    output logic cycle_active_flag,
    output logic lockout_state,
    output logic recloser_in_service
);
    initial if (TICK_LEN < 2) $error("rsm_top: tick too short");
    // bus slave: zero wait states, always okay
    logic ap_r, wr_r;
    logic [7:0] addr_r;
    logic [31:0] ctrl_r, seq_r;
    logic [9:0] phase_ct_ratio, ground_ct_ratio;
    logic [13:0] station_number;
    logic [3:0] cal_sel_r;
    logic login_ok_r;
    wire take = hsel && htrans[1] && hready;
    wire wdat = ap_r && wr_r;
    wire w_ctrl = wdat && addr_r == A_CTRL;
    wire w_ct = wdat && addr_r == A_CT;
    wire w_seq = wdat && addr_r == A_SEQ;
    wire w_stn = wdat && addr_r == A_STN;
    wire w_login = wdat && addr_r == A_LOGIN;
    wire w_sel = wdat && addr_r == A_CALSEL;
    wire w_cal = wdat && addr_r == A_CALDAT;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            ap_r <= take;
            wr_r <= hwrite;
            addr_r <= {haddr[7:2], 2'b00};
        end
    end
    wire restart_position_memory = ctrl_r[CTRL_RPM];
    wire reclose_enable = ctrl_r[CTRL_REN];
    wire [2:0] output_retention_select = ctrl_r[CTRL_ORS+:3];
    wire [1:0] demand_interval_code = ctrl_r[CTRL_DMD+:2];
    wire [2:0] baud_code = ctrl_r[CTRL_BAUD+:3];
    wire [7:0] period_delay = seq_r[7:0];
    wire [1:0] last_period = seq_r[SEQ_NPER+:2];
    wire [7:0] reset_hold_time = seq_r[SEQ_HOLD+:8];
    wire [9:0] wr_pct = hwdata[9:0];
    wire [9:0] wr_gct = hwdata[CT_GND+:10];
    wire ct_ok = wr_pct != 10'h000 && wr_pct <= CT_MAX && wr_gct != 10'h000 && wr_gct <= CT_MAX;
    wire dmd_ok = hwdata[CTRL_DMD+:2] != 2'h3;
    wire baud_ok = hwdata[CTRL_BAUD+:3] <= 3'h4;
    wire hold_ok = hwdata[SEQ_HOLD+:8] != 8'h00 && hwdata[SEQ_HOLD+:8] <= HOLD_MAX;
    wire dly_ok = hwdata[7:0] != 8'h00;
    wire stn_ok = hwdata[13:0] <= STN_MAX;
    wire cal_ok = hwdata[6:0] <= CAL_MAX;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
            phase_ct_ratio <= CT_RST;
            ground_ct_ratio <= CT_RST;
            seq_r <= {8'h00, HOLD_RST, 8'h00, DLY_RST};
            station_number <= 14'h0000;
            cal_sel_r <= 4'h0;
        end else begin
            if (w_ctrl && dmd_ok && baud_ok) ctrl_r <= hwdata & 32'h0000_731F;
            if (w_ct && ct_ok) begin
                phase_ct_ratio <= wr_pct;
                ground_ct_ratio <= wr_gct;
            end
            if (w_seq && hold_ok && dly_ok) seq_r <= hwdata & 32'h00FF_03FF;
            if (w_stn && stn_ok) station_number <= hwdata[13:0];
            if (w_sel) cal_sel_r <= hwdata[3:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            login_ok_r <= 1'b0;
        end else if (w_login) begin
            login_ok_r <= hwdata[13:0] == station_number && hwdata[31:14] == 18'h00000;
        end else if (w_stn) begin
            login_ok_r <= 1'b0;
        end
    end
    assign login_ok = login_ok_r;
    // calibration codes and per-channel scaling
    logic [4:0][3:0] cal_raddr;
    logic [4:0][6:0] cal_rdata;
    rsm_calmem #(.DEPTH(CAL_CNT), .NRD(5)) u_cal (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(w_cal && cal_ok),
        .waddr(cal_sel_r),
        .wdata(hwdata[6:0]),
        .raddr(cal_raddr),
        .rdata(cal_rdata)
    );
    assign cal_raddr[4] = cal_sel_r;
    // gain code only; magnetics factor is unity
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            assign cal_raddr[gi] = 4'(gi * 3) + {2'b00, meas.gain};
            rsm_scale #(.IW(16), .OW(32)) u_scale (
                .hclk(hclk),
                .hresetn(hresetn),
                .amps(meas.amps[gi]),
                .ratio(gi == 3 ? ground_ct_ratio : phase_ct_ratio),
                .code(cal_rdata[gi]),
                .primary(amps_primary[gi])
            );
        end
    endgenerate
    wire [6:0] cal_view = cal_sel_r < 4'(CAL_CNT) ? cal_rdata[4] : 7'h00;
    wire [5:0] dmd_min = demand_interval_code == 2'h0 ? 6'h0F : demand_interval_code == 2'h1 ? 6'h1E : 6'h3C;
    wire [13:0] baud_val = baud_code == 3'h0 ? 14'h012C : baud_code == 3'h1 ? 14'h04B0 :
        baud_code == 3'h2 ? 14'h0960 : baud_code == 3'h3 ? 14'h12C0 : 14'h2580;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) comm <= '0;
        else comm <= '{baud_rate: baud_val, demand_minutes: dmd_min};
    end
    // power_ok and breaker_closed pass a two-stage synchroniser; trip is used unsynchronised
    logic [1:0] pok_q, brk_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pok_q <= 2'b00;
            brk_q <= 2'b00;
        end else begin
            pok_q <= {pok_q[0], power_ok};
            brk_q <= {brk_q[0], breaker_closed};
        end
    end
    wire pok_s = pok_q[1];
    wire brk_s = brk_q[1];
    // one-second tick
    logic [31:0] div_r;
    wire tick = div_r == 32'(TICK_LEN - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) div_r <= 32'h0000_0000;
        else div_r <= tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
    end
    // reclose sequencer with power-loss memory
    rsm_state_t state_r, state_nxt;
    logic [1:0] period_r, period_nxt, saved_period_r;
    logic [7:0] cnt_r, cnt_nxt;
    logic spare_r, spare_nxt, cyc_r, cyc_nxt, lo_r, lo_nxt, rec_nxt, rec_r;
    logic saved_cyc_r, saved_spare_r, saved_act_r, saved_lo_r;
    wire going_down = !pok_s && state_r != ST_DOWN;
    wire back_up = pok_s && state_r == ST_DOWN;
    wire last = period_r == last_period;
    always_comb begin
        state_nxt = state_r;
        period_nxt = period_r;
        cnt_nxt = cnt_r;
        spare_nxt = spare_r;
        cyc_nxt = cyc_r;
        lo_nxt = lo_r;
        rec_nxt = 1'b0;
        if (going_down) begin
            state_nxt = ST_DOWN;
        end else if (back_up) begin
            spare_nxt = output_retention_select[2] && saved_spare_r;
            cyc_nxt = output_retention_select[1] && saved_act_r;
            lo_nxt = output_retention_select[0] && saved_lo_r;
            if (!reclose_enable) begin
                state_nxt = ST_IDLE;
            end else if (restart_position_memory && saved_cyc_r) begin
                // same period, countdown from full delay
                state_nxt = ST_CYCLE;
                period_nxt = saved_period_r;
                cnt_nxt = period_delay;
                cyc_nxt = 1'b1;
            end else if (brk_s) begin
                // breaker closed comes up in reset
                state_nxt = ST_RESET;
            end else begin
                state_nxt = ST_LOCKOUT;
                lo_nxt = 1'b1;
            end
        end else if (state_r == ST_DOWN) begin
            state_nxt = ST_DOWN;
        end else if (!reclose_enable) begin
            state_nxt = ST_IDLE;
            spare_nxt = 1'b0;
            cyc_nxt = 1'b0;
            lo_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_nxt = brk_s ? ST_RESET : ST_LOCKOUT;
                    lo_nxt = !brk_s;
                end
                ST_RESET: begin
                    if (trip) begin
                        state_nxt = ST_CYCLE;
                        period_nxt = 2'h0;
                        cnt_nxt = period_delay;
                        cyc_nxt = 1'b1;
                    end
                end
                ST_CYCLE: begin
                    // countdown end gives reclose, sequence goes on
                    if (tick && cnt_r <= 8'h01) begin
                        rec_nxt = 1'b1;
                        spare_nxt = 1'b1;
                        state_nxt = ST_HOLD;
                        cnt_nxt = reset_hold_time;
                    end else if (tick) begin
                        cnt_nxt = cnt_r - 8'h01;
                    end
                end
                ST_HOLD: begin
                    // reset only after closed for hold time
                    if (trip) begin
                        if (lo_r || last) begin
                            state_nxt = ST_LOCKOUT;
                            lo_nxt = 1'b1;
                            cyc_nxt = 1'b0;
                        end else begin
                            state_nxt = ST_CYCLE;
                            period_nxt = period_r + 2'h1;
                            cnt_nxt = period_delay;
                        end
                    end else if (!brk_s) begin
                        cnt_nxt = reset_hold_time;
                    end else if (tick && cnt_r <= 8'h01) begin
                        state_nxt = ST_RESET;
                        spare_nxt = 1'b0;
                        cyc_nxt = 1'b0;
                        lo_nxt = 1'b0;
                    end else if (tick) begin
                        cnt_nxt = cnt_r - 8'h01;
                    end
                end
                ST_LOCKOUT: begin
                    if (brk_s) begin
                        state_nxt = ST_HOLD;
                        cnt_nxt = reset_hold_time;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_DOWN;
            period_r <= 2'h0;
            cnt_r <= 8'h00;
            {spare_r, cyc_r, lo_r, rec_r} <= 4'h0;
        end else begin
            state_r <= state_nxt;
            period_r <= period_nxt;
            cnt_r <= cnt_nxt;
            {spare_r, cyc_r, lo_r, rec_r} <= {spare_nxt, cyc_nxt, lo_nxt, rec_nxt};
        end
    end
    // snapshot at power loss; cleared only by a cold reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            saved_period_r <= 2'h0;
            {saved_cyc_r, saved_spare_r, saved_act_r, saved_lo_r} <= 4'h0;
        end else if (going_down) begin
            saved_period_r <= period_r;
            saved_cyc_r <= state_r == ST_CYCLE;
            {saved_spare_r, saved_act_r, saved_lo_r} <= {spare_r, cyc_r, lo_r};
        end
    end
    assign reclose_out = rec_r;
    assign spare_output = spare_r;
    assign cycle_active_flag = cyc_r;
    assign lockout_state = lo_r;
    assign recloser_in_service = state_r != ST_IDLE && state_r != ST_DOWN;
    // read mux from registered sources
    always_comb begin
        case (addr_r)
            A_CTRL: hrdata = ctrl_r;
            A_CT: hrdata = {6'h00, ground_ct_ratio, 6'h00, phase_ct_ratio};
            A_SEQ: hrdata = seq_r;
            A_STN: hrdata = {18'h00000, station_number};
            A_LOGIN: hrdata = {31'h0, login_ok_r};
            A_CALSEL: hrdata = {28'h0, cal_sel_r};
            A_CALDAT: hrdata = {25'h0, cal_view};
            A_STAT: hrdata = {16'h0, cnt_r, 1'b0, state_r, spare_r, cyc_r, lo_r, rec_r};
            default: hrdata = 32'h0000_0000;
        endcase
    end
    sequence s_return;
        state_r == ST_DOWN && pok_s && reclose_enable;
    endsequence
    restart_resume_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_return and restart_position_memory && saved_cyc_r |=> state_r == ST_CYCLE && cnt_r == period_delay)
        else $error("restart did not resume period");
    reset_closed_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_return and !restart_position_memory && brk_s |=> state_r == ST_RESET)
        else $error("no reset on closed breaker");
    lockout_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_return and !restart_position_memory && !brk_s |=> state_r == ST_LOCKOUT && lo_r)
        else $error("no lockout on open breaker");
    spare_retain_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_return and !output_retention_select[2] |=> !spare_r)
        else $error("spare kept without retention");
    disable_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !reclose_enable && pok_s && state_r != ST_DOWN |=> state_r == ST_IDLE && !recloser_in_service)
        else $error("recloser active while disabled");
    ct_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        phase_ct_ratio != 10'h000 && phase_ct_ratio <= CT_MAX && ground_ct_ratio != 10'h000 && ground_ct_ratio <= CT_MAX)
        else $error("ct ratio out of range");
    demand_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        demand_interval_code == 2'h1 ##1 demand_interval_code == 2'h1 |-> comm.demand_minutes == 6'h1E)
        else $error("demand window wrong");
    baud_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
        baud_code == 3'h4 ##1 baud_code == 3'h4 |-> comm.baud_rate == 14'h2580)
        else $error("baud decode wrong");
    login_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        w_login && hwdata[13:0] != station_number |=> !login_ok)
        else $error("login with wrong station");
    reclose_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        reclose_out && pok_s && reclose_enable |-> state_r == ST_HOLD && cnt_r == reset_hold_time)
        else $error("reclose without hold start");
endmodule : rsm_top

//--- verification/rsm_breaker_model.sv
// breaker status contact model facing the recloser
`timescale 1ns/1ps
module rsm_breaker_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic trip,
    input wire logic reclose_out,
    output logic breaker_closed
);
    // opens on trip, closes only on a reclose pulse; no manual close, so lockout sticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            breaker_closed <= 1'b1;
        end else if (trip) begin
            breaker_closed <= 1'b0;
        end else if (reclose_out) begin
            breaker_closed <= 1'b1;
        end
    end
endmodule : rsm_breaker_model

//--- verification/tb.sv
// self-checking bench for the reclose settings memory
`timescale 1ns/1ps
module tb;
    import rsm_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, trip = 1'b0, power_ok = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rv;
    rsm_meas_t meas = '0;
    logic hreadyout, hresp, login_ok, reclose_out, spare_output, cycle_active_flag, lockout_state;
    logic recloser_in_service, breaker_closed;
    logic [3:0][31:0] amps_primary;
    rsm_comm_t comm;
    int num_errors = 0, n_tests = 0;
    int dm[3] = '{15, 30, 60};
    int bd[5] = '{300, 1200, 2400, 4800, 9600};
    always #20 hclk = ~hclk;
    // ten-cycle tick keeps second-scale counts to one or two hundred cycles
    rsm_top #(.TICK_LEN(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_ok(power_ok),
        .breaker_closed(breaker_closed), .trip(trip), .meas(meas), .amps_primary(amps_primary),
        .comm(comm), .login_ok(login_ok), .reclose_out(reclose_out), .spare_output(spare_output),
        .cycle_active_flag(cycle_active_flag), .lockout_state(lockout_state),
        .recloser_in_service(recloser_in_service));
    rsm_breaker_model brk_u (.hclk(hclk), .hresetn(hresetn), .trip(trip), .reclose_out(reclose_out),
        .breaker_closed(breaker_closed));
    task tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 20);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            tally_and_finish;
        end
    endtask : rdy
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdy;
        rv = hrdata;
    endtask : xfer
    task wait_st(input logic [2:0] exp);
        for (int i = 0; i < 100; i++) begin
            xfer(1'b0, A_STAT, 32'h0);
            if (rv[6:4] === exp) break;
        end
        chk({29'h0, rv[6:4]}, {29'h0, exp}, "state");
    endtask : wait_st
    task pwr;
        @(posedge hclk);
        power_ok <= 1'b0;
        repeat (10) @(posedge hclk);
        power_ok <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask : pwr
    task pulse_trip;
        @(posedge hclk);
        trip <= 1'b1;
        @(posedge hclk);
        trip <= 1'b0;
    endtask : pulse_trip
    task t_reset;
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'h0000_0002, "ctrl reset");
        xfer(1'b0, A_CT, 32'h0);
        chk(rv, 32'h0001_0001, "ct reset");
        xfer(1'b0, A_SEQ, 32'h0);
        chk(rv, 32'h000A_000F, "seq reset");
        chk({31'h0, recloser_in_service}, 32'h1, "in service");
    endtask : t_reset
    task t_settings;
        xfer(1'b1, A_CT, 32'h0000_0000);
        xfer(1'b1, A_CT, 32'h03E9_0001);
        xfer(1'b0, A_CT, 32'h0);
        chk(rv, 32'h0001_0001, "ct refused");
        xfer(1'b1, A_CT, 32'h03E8_03E8);
        xfer(1'b0, A_CT, 32'h0);
        chk(rv, 32'h03E8_03E8, "ct max");
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, A_CTRL, 32'h2 | (i << 8));
            repeat (2) @(posedge hclk);
            chk({26'h0, comm.demand_minutes}, dm[i], "demand");
        end
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, A_CTRL, 32'h2 | (i << 12));
            repeat (2) @(posedge hclk);
            chk({18'h0, comm.baud_rate}, bd[i], "baud");
        end
        xfer(1'b1, A_CTRL, 32'h0000_0302);
        xfer(1'b1, A_CTRL, 32'h0000_5002);
        xfer(1'b0, A_CTRL, 32'h0);
        chk(rv, 32'h0000_4002, "ctrl refused");
    endtask : t_settings
    task t_login;
        xfer(1'b1, A_STN, 32'd9999);
        xfer(1'b1, A_STN, 32'd10000);
        xfer(1'b0, A_STN, 32'h0);
        chk(rv, 32'h0000_270F, "station");
        xfer(1'b1, A_LOGIN, 32'd9999);
        repeat (2) @(posedge hclk);
        chk({31'h0, login_ok}, 32'h1, "good login");
        xfer(1'b1, A_LOGIN, 32'd1234);
        repeat (2) @(posedge hclk);
        chk({31'h0, login_ok}, 32'h0, "bad login");
    endtask : t_login
    task t_cal;
        xfer(1'b1, A_CALSEL, 32'h0);
        @(posedge hclk);
        xfer(1'b0, A_CALDAT, 32'h0);
        chk(rv, 32'h0000_0032, "cal reset");
        xfer(1'b1, A_CALDAT, 32'd99);
        xfer(1'b1, A_CALDAT, 32'd100);
        xfer(1'b0, A_CALDAT, 32'h0);
        chk(rv, 32'd99, "cal max");
        meas.amps[0] <= 16'd1000;
        repeat (4) @(posedge hclk);
        chk(amps_primary[0], 32'd1049000, "scale 99");
        xfer(1'b1, A_CALDAT, 32'd0);
        repeat (4) @(posedge hclk);
        chk(amps_primary[0], 32'd950000, "scale 0");
        meas.gain <= 2'h1;
        repeat (4) @(posedge hclk);
        chk(amps_primary[0], 32'd1000000, "scale unity");
        xfer(1'b1, A_CALSEL, 32'd12);
        @(posedge hclk);
        xfer(1'b0, A_CALDAT, 32'h0);
        chk(rv, 32'h0, "magnetics hidden");
    endtask : t_cal
    task t_memory;
        xfer(1'b1, A_CTRL, 32'h0000_001F);
        wait_st(3'h1);
        pulse_trip;
        repeat (70) @(posedge hclk);
        pwr;
        wait_st(3'h2);
        chk({31'h0, rv[15:8] >= 8'd14}, 32'h1, "full delay");
        chk({31'h0, cycle_active_flag}, 32'h1, "active kept");
        for (int i = 0; i < 400; i++) begin
            @(posedge hclk);
            if (reclose_out === 1'b1) break;
        end
        chk({31'h0, reclose_out}, 32'h1, "reclose");
        chk({31'h0, spare_output}, 32'h1, "spare on reclose");
        wait_st(3'h3);
        repeat (40) @(posedge hclk);
        xfer(1'b0, A_STAT, 32'h0);
        chk({29'h0, rv[6:4]}, 32'h3, "hold early");
        wait_st(3'h1);
        chk({31'h0, spare_output}, 32'h0, "spare cleared");
    endtask : t_memory
    task t_nomem;
        xfer(1'b1, A_CTRL, 32'h0000_0002);
        pwr;
        wait_st(3'h1);
        pulse_trip;
        repeat (20) @(posedge hclk);
        pwr;
        wait_st(3'h4);
        chk({31'h0, lockout_state}, 32'h1, "lockout");
        chk({31'h0, cycle_active_flag}, 32'h0, "active dropped");
        xfer(1'b1, A_CTRL, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, recloser_in_service}, 32'h0, "disabled");
    endtask : t_nomem
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        t_reset;
        t_settings;
        t_login;
        t_cal;
        t_memory;
        t_nomem;
        tally_and_finish;
    end
endmodule : tb
